/* include/prs_pkg.sv */
package prs_pkg;

   // ----------------------------------------------------------------
   // register widths
   // ----------------------------------------------------------------
   localparam int SER_W  = 8;
   localparam int BITBUF_W = 16;
   localparam int PORT_W = 8;
   localparam int IRQ_W  = 8;
   localparam int ADDR_W = 8;
   localparam int SEG_N  = 12;
   localparam int COM_N  = 4;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]       CLR8_RST       = 8'h00;
   localparam logic [7:0]       CONV_MODE_RST  = 8'h04;
   localparam logic [7:0]       SAR_RST        = 8'h7f;
   localparam logic [BITBUF_W-1:0] BITBUF_RST  = 16'h0000;
   localparam logic [1:0]       IRQ_EDGE_RST   = 2'h0;
   localparam logic [IRQ_W-1:0] IRQ_CLR_RST    = 8'h00;
   localparam logic [PORT_W-1:0] PORT_CLR_RST  = 8'h00;
   localparam logic [SER_W-1:0] UNDEF_FILL     = 8'h00;

   // ----------------------------------------------------------------
   // field positions and ranges
   // ----------------------------------------------------------------
   localparam int CONV_EOC_BIT = 2;
   localparam logic [ADDR_W-1:0] VOLATILE_LO = 8'hf8;
   localparam logic [ADDR_W-1:0] VOLATILE_HI = 8'hfd;

   // ----------------------------------------------------------------
   // lcd drive level select codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PRS_LEVEL0 = 2'b00,
      PRS_LEVEL1 = 2'b01,
      PRS_LEVEL2 = 2'b10
   } prs_level_type;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PRS_IN_RESET = 2'b00,
      PRS_RUN      = 2'b01
   } prs_state_type;

endpackage

/* rtl/prs_reset_init.sv */
// Functional notes
// - standby reset keeps serial, address, bit buffer
// - operating reset: serial undefined, buffer specified
// - any reset clears external edge configs
// - data memory F8-FD lost on reset
// - segments level1, com0-2 level2, com3 level0
`timescale 1ns/1ps
`default_nettype none
module prs_reset_init
   import prs_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                nrst_i,
   // power state from the core, pin level
   input  wire logic                standby_i,
   // software writes to the state kept across standby
   input  wire logic                ser_we_i,
   input  wire logic [SER_W-1:0]    ser_wdata_i,
   input  wire logic                addr_we_i,
   input  wire logic [SER_W-1:0]    addr_wdata_i,
   input  wire logic                bitbuf_we_i,
   input  wire logic [BITBUF_W-1:0] bitbuf_wdata_i,
   // data memory location query
   input  wire logic [ADDR_W-1:0]   mem_addr_i,
   output logic                     mem_volatile_o,
   // retained state
   output logic [SER_W-1:0]         serial_shift_register_o,
   output logic [SER_W-1:0]         slave_match_address_o,
   output logic [BITBUF_W-1:0]      bit_sequence_buffer_o,
   output logic                     retained_valid_o,
   // state forced to its reset values
   output logic [1:0]               ext_irq_edge_config_o [3],
   output logic [7:0]               serial_mode_reg_o,
   output logic [7:0]               serial_bus_control_reg_o,
   output logic [7:0]               cpu_clock_select_reg_o,
   output logic [7:0]               system_clock_select_reg_o,
   output logic [7:0]               clock_out_config_reg_o,
   output logic [7:0]               display_mode_reg_o,
   output logic [7:0]               display_control_reg_o,
   output logic [7:0]               converter_mode_reg_o,
   output logic                     conv_end_o,
   output logic [7:0]               sar_o,
   output logic                     global_irq_enable_o,
   output logic [IRQ_W-1:0]         irq_enable_flags_o,
   output logic [IRQ_W-1:0]         irq_request_flags_o,
   output logic [PORT_W-1:0]        port_direction_regs_o [3],
   output logic [PORT_W-1:0]        pullup_select_regs_o [2],
   output logic [PORT_W-1:0]        port_latch_o,
   // lcd drive level selection
   output logic [1:0]               lcd_segment_outputs_o [SEG_N],
   output logic [1:0]               lcd_common_outputs_o [COM_N]
);

   // ----------------------------------------------------------------
   // standby sampling
   // ----------------------------------------------------------------
   logic          standby_s;
   logic          was_standby;
   logic          first_cycle;
   prs_state_type state;
   prs_state_type next_state;

   // the synchroniser must not be cleared by the reset whose cause it
   // reports, so it keeps sampling the pin while reset is low
   prs_sync u_standby_sync (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (1'b1),
      .async_i   (standby_i),
      .sync_o    (standby_s)
   );

   // the standby flag must survive the asynchronous reset itself, so it
   // is a plain clocked flop with no reset term
   always_ff @(posedge clk_sys_i) begin
      was_standby <= standby_s;
   end

   // ----------------------------------------------------------------
   // reset sequencing
   // ----------------------------------------------------------------
   assign next_state  = PRS_RUN;
   assign first_cycle = (state == PRS_IN_RESET);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= PRS_IN_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // retained registers: serial, address and bit buffer have no reset term so standby contents survive
   // ----------------------------------------------------------------
   logic [SER_W-1:0]    ser_q;
   logic [SER_W-1:0]    addr_q;
   logic [BITBUF_W-1:0] bitbuf_q;
   logic                valid_q;
   logic                lost_on_reset;

   // an operating reset leaves serial contents undefined; we load UNDEF_FILL and
   // flag them invalid rather than scramble them, which costs nothing extra
   assign lost_on_reset = first_cycle && !was_standby;

   always_ff @(posedge clk_sys_i) begin
      if (ser_we_i) begin
         ser_q <= ser_wdata_i;
      end else if (lost_on_reset) begin
         ser_q <= UNDEF_FILL;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (addr_we_i) begin
         addr_q <= addr_wdata_i;
      end else if (lost_on_reset) begin
         addr_q <= UNDEF_FILL;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (bitbuf_we_i) begin
         bitbuf_q <= bitbuf_wdata_i;
      end else if (lost_on_reset) begin
         bitbuf_q <= BITBUF_RST;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         valid_q <= 1'b0;
      end else if (first_cycle) begin
         valid_q <= was_standby;
      end else if (ser_we_i || addr_we_i) begin
         valid_q <= 1'b1;
      end
   end

   assign serial_shift_register_o = ser_q;
   assign slave_match_address_o   = addr_q;
   assign bit_sequence_buffer_o   = bitbuf_q;
   assign retained_valid_o        = valid_q;

   // ----------------------------------------------------------------
   // volatile data memory window
   // ----------------------------------------------------------------
   function automatic logic in_volatile(input logic [ADDR_W-1:0] a);
      in_volatile = (a >= VOLATILE_LO) && (a <= VOLATILE_HI);
   endfunction

   assign mem_volatile_o = in_volatile(mem_addr_i);

   // ----------------------------------------------------------------
   // control state held at reset value: cleared, except converter mode 04 and sar 7f
   // ----------------------------------------------------------------
   localparam int CTRL_N = 7;

   logic [7:0] conv_mode_q;
   logic [7:0] sar_q;
   logic [7:0] ctrl_q [CTRL_N];

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         conv_mode_q <= CONV_MODE_RST;
         sar_q       <= SAR_RST;
      end else begin
         conv_mode_q <= conv_mode_q;
         sar_q       <= sar_q;
      end
   end

   genvar gi;
   generate
      // the core owns these registers once running; this block only fixes
      // the value they start from, so each flop simply holds it
      for (gi = 0; gi < CTRL_N; gi++) begin : g_ctrl
         always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               ctrl_q[gi] <= CLR8_RST;
            end else begin
               ctrl_q[gi] <= ctrl_q[gi];
            end
         end
      end
      for (gi = 0; gi < 3; gi++) begin : g_edge
         assign ext_irq_edge_config_o[gi] = IRQ_EDGE_RST;
         assign port_direction_regs_o[gi] = PORT_CLR_RST;
      end
      for (gi = 0; gi < 2; gi++) begin : g_pull
         assign pullup_select_regs_o[gi] = PORT_CLR_RST;
      end
      for (gi = 0; gi < SEG_N; gi++) begin : g_seg
         assign lcd_segment_outputs_o[gi] = PRS_LEVEL1;
      end
      for (gi = 0; gi < COM_N - 1; gi++) begin : g_com
         assign lcd_common_outputs_o[gi] = PRS_LEVEL2;
      end
   endgenerate

   assign lcd_common_outputs_o[COM_N-1] = PRS_LEVEL0;

   assign serial_mode_reg_o         = ctrl_q[0];
   assign serial_bus_control_reg_o  = ctrl_q[1];
   assign cpu_clock_select_reg_o    = ctrl_q[2];
   assign system_clock_select_reg_o = ctrl_q[3];
   assign clock_out_config_reg_o    = ctrl_q[4];
   assign display_mode_reg_o        = ctrl_q[5];
   assign display_control_reg_o     = ctrl_q[6];
   assign converter_mode_reg_o      = conv_mode_q;
   assign conv_end_o                = conv_mode_q[CONV_EOC_BIT];
   assign sar_o                     = sar_q;
   assign global_irq_enable_o       = 1'b0;
   assign irq_enable_flags_o        = IRQ_CLR_RST;
   assign irq_request_flags_o       = IRQ_CLR_RST;
   assign port_latch_o              = PORT_CLR_RST;

endmodule
`default_nettype wire

/* rtl/prs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module prs_sync
   import prs_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   // asynchronous level in, synchronised level out
   input  wire logic async_i,
   output logic      sync_o
);
   logic stage1;
   logic stage2;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;
endmodule
`default_nettype wire

/* test/prs_reset_init_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module prs_reset_init_bench;
   import prs_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i, standby_i, mem_volatile_o, retained_valid_o, conv_end_o, global_irq_enable_o;
   logic ser_we_i = 1'b0, addr_we_i = 1'b0, bitbuf_we_i = 1'b0;
   logic [7:0] ser_wdata_i = 8'h00, addr_wdata_i = 8'h00, mem_addr_i = 8'h00, s, a;
   logic [15:0] bitbuf_wdata_i = 16'h0000, bit_sequence_buffer_o, b;
   logic [7:0] serial_shift_register_o, slave_match_address_o, serial_mode_reg_o, sar_o;
   logic [7:0] serial_bus_control_reg_o, cpu_clock_select_reg_o, system_clock_select_reg_o;
   logic [7:0] clock_out_config_reg_o, display_mode_reg_o, display_control_reg_o;
   logic [7:0] converter_mode_reg_o, irq_enable_flags_o, irq_request_flags_o, port_latch_o;
   logic [7:0] port_direction_regs_o [3], pullup_select_regs_o [2], clr [15];
   logic [1:0] ext_irq_edge_config_o [3], lcd_segment_outputs_o [SEG_N];
   logic [1:0] lcd_common_outputs_o [COM_N];
   int fails = 0, n_tests = 0;
   assign clr = '{serial_mode_reg_o, serial_bus_control_reg_o, cpu_clock_select_reg_o,
      system_clock_select_reg_o, clock_out_config_reg_o, display_mode_reg_o,
      display_control_reg_o, irq_enable_flags_o, irq_request_flags_o, port_latch_o,
      port_direction_regs_o[0], port_direction_regs_o[1], port_direction_regs_o[2],
      pullup_select_regs_o[0], pullup_select_regs_o[1]};
   prs_reset_init uut (.*);
   prs_reset_src src (.clk_sys_i(clk_sys_i), .nrst_o(nrst_i), .standby_o(standby_i));
   always #12.5 clk_sys_i = ~clk_sys_i;
   // ------
   // expectations and checking
   // ------
   function automatic logic [1:0] com_exp(input int i);
      return (i == COM_N - 1) ? PRS_LEVEL0 : PRS_LEVEL2;
   endfunction
   function automatic logic vol_exp(input logic [7:0] x);
      return x >= 8'hf8 && x <= 8'hfd;
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic st(input logic [7:0] es, input logic [7:0] ea, input logic [15:0] eb,
                     input logic rv);
      chk("serial", serial_shift_register_o, es);
      chk("address", slave_match_address_o, ea);
      chk("bitbuf", bit_sequence_buffer_o, eb);
      chk("valid", retained_valid_o, rv);
      chk("adc", {sar_o, converter_mode_reg_o}, 16'h7f04);
      chk("eoc_ime", {conv_end_o, global_irq_enable_o}, 2'b10);
      for (int i = 0; i < 15; i++) chk($sformatf("clr%0d", i), clr[i], 8'h00);
      for (int i = 0; i < 3; i++) chk("edge", ext_irq_edge_config_o[i], 2'b00);
      for (int i = 0; i < SEG_N; i++) chk("seg", lcd_segment_outputs_o[i], PRS_LEVEL1);
      for (int i = 0; i < COM_N; i++) chk("com", lcd_common_outputs_o[i], com_exp(i));
   endtask
   // strobes stay high across the burst so writes run back to back
   task automatic wr(input int n);
      {ser_we_i, addr_we_i, bitbuf_we_i} = 3'b111;
      repeat (n) begin
         {s, a, b} = 32'($urandom);
         {ser_wdata_i, addr_wdata_i, bitbuf_wdata_i} = {s, a, b};
         @(posedge clk_sys_i);
         #2;
         chk("serial", serial_shift_register_o, s);
         chk("address", slave_match_address_o, a);
         chk("bitbuf", bit_sequence_buffer_o, b);
      end
      {ser_we_i, addr_we_i, bitbuf_we_i} = 3'b000;
   endtask
   // ------
   // main sequence
   // ------
   initial begin
      void'($urandom(32'h02e49115));
      repeat (16) @(posedge clk_sys_i);
      #2;
      src.pulse(1'b0);
      st(8'h00, 8'h00, 16'h0000, 1'b0);
      for (int i = 0; i < 256; i++) begin
         mem_addr_i = 8'(i);
         @(posedge clk_sys_i);
         #2;
         chk("volatile", mem_volatile_o, vol_exp(8'(i)));
      end
      wr(6);
      src.pulse(1'b1);
      st(s, a, b, 1'b1);
      wr(3);
      src.pulse(1'b0);
      st(8'h00, 8'h00, 16'h0000, 1'b0);
      end_sim;
   end
endmodule
`default_nettype wire

/* test/prs_reset_init_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module prs_reset_init_properties
   import prs_pkg::*;
(
   // watched ports
   input wire logic              clk_sys_i,
   input wire logic              nrst_i,
   input wire logic              ser_we_i,
   input wire logic [SER_W-1:0]  ser_wdata_i,
   input wire logic [ADDR_W-1:0] mem_addr_i,
   input wire logic              mem_volatile_o,
   input wire logic [SER_W-1:0]  serial_shift_register_o,
   input wire logic              retained_valid_o,
   input wire logic [1:0]        ext_irq_edge_config_o [3],
   input wire logic [7:0]        serial_mode_reg_o,
   input wire logic [7:0]        converter_mode_reg_o,
   input wire logic              conv_end_o,
   input wire logic [7:0]        sar_o,
   input wire logic [1:0]        lcd_segment_outputs_o [SEG_N],
   input wire logic [1:0]        lcd_common_outputs_o [COM_N]
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // first edge after release is skipped: the register reloads there
   sequence s_write;
      ser_we_i && $past(nrst_i);
   endsequence
   sequence s_idle;
      !ser_we_i && $past(nrst_i);
   endsequence
   a_write_lands: assert property (s_write |=> serial_shift_register_o == $past(ser_wdata_i) && retained_valid_o) else $error("serial write lost");
   a_idle_kept: assert property (s_idle |=> $stable(serial_shift_register_o)) else $error("serial value drifted");
   a_clean_start: assert property (!retained_valid_o && $past(nrst_i) |-> serial_shift_register_o == 8'h00) else $error("serial not cleared");
   a_edge_cfg_zero: assert property (ext_irq_edge_config_o[0] == 2'b00 && ext_irq_edge_config_o[1] == 2'b00 && ext_irq_edge_config_o[2] == 2'b00) else $error("edge config set");
   a_volatile_window: assert property (mem_volatile_o == (mem_addr_i >= 8'hf8 && mem_addr_i <= 8'hfd)) else $error("volatile range wrong");
   a_lcd_levels: assert property (lcd_segment_outputs_o[0] == PRS_LEVEL1 && lcd_segment_outputs_o[SEG_N-1] == PRS_LEVEL1 && lcd_common_outputs_o[0] == PRS_LEVEL2 && lcd_common_outputs_o[2] == PRS_LEVEL2 && lcd_common_outputs_o[3] == PRS_LEVEL0) else $error("lcd level wrong");
   a_conv_reset: assert property (converter_mode_reg_o == 8'h04 && conv_end_o && sar_o == 8'h7f) else $error("converter reset wrong");
   a_mode_clear: assert property (serial_mode_reg_o == 8'h00) else $error("serial mode set");
endmodule
bind prs_reset_init prs_reset_init_properties props (.*);
`default_nettype wire

/* test/prs_reset_src.sv */
`timescale 1ns/1ps
`default_nettype none
module prs_reset_src (
   // clock in, reset and power state out
   input  wire logic clk_sys_i,
   output logic      nrst_o,
   output logic      standby_o
);
   // power-on reset held for sixteen clocks, then released off the edge
   initial begin
      nrst_o = 1'b0;
      standby_o = 1'b0;
      repeat (16) @(posedge clk_sys_i);
      #2 nrst_o = 1'b1;
   end
   // standby held past release so the synchroniser sees it settle
   task automatic pulse(input logic stby);
      standby_o = stby;
      repeat (4) @(posedge clk_sys_i);
      #2 nrst_o = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #2 nrst_o = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      #2 standby_o = 1'b0;
   endtask
endmodule
`default_nettype wire
